// ==== bench/bounds_ext_mode_branch_control_properties.sv ====
// Port-level assertions for the bounds-extension control block
`timescale 1ns/1ps
`default_nettype none
module bounds_ext_checker (
    input wire i_core_clk,
    input wire i_reset_n,
    input wire i_ce,
    input wire i_dec_valid,
    input wire [1:0] i_mode,
    input wire i_is_ext_instr,
    input wire i_is_mem_form,
    input wire i_repeat_not_equal_prefix,
    input wire [7:0] i_opc0,
    input wire i_system_mgmt_interrupt,
    input wire i_system_mgmt_return,
    input wire i_vm_exit,
    input wire i_vm_entry,
    input wire i_entry_restore_config_control,
    input wire o_opnd_64,
    input wire o_addr_64,
    input wire o_invalid_opcode_fault,
    input wire o_bound_init,
    input wire o_smm_save_valid,
    input wire [15:0] o_smm_save_offset,
    input wire o_guest_store_valid,
    input wire o_vm_entry_fail
);
    // Decode request really taken; a low enable freezes the block
    wire dv = i_dec_valid && i_ce;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    // Width selection and fault causes, one cycle after the request
    a_long_mode_width: assert property (dv && i_mode == 2'h2 |=> o_opnd_64 && o_addr_64)
        else $error("long mode decode not 64-bit wide");
    a_legacy_mode_width: assert property (dv && i_mode != 2'h2 |=> !o_opnd_64 && !o_addr_64)
        else $error("legacy mode decode not 32-bit wide");
    a_fault_has_cause: assert property (o_invalid_opcode_fault |->
        $past(dv && i_is_ext_instr && i_is_mem_form && i_mode != 2'h2))
        else $error("invalid opcode fault without a cause");
    a_regform_no_fault: assert property (dv && !i_is_mem_form |=> !o_invalid_opcode_fault)
        else $error("register form raised a fault");
    // Branches that must never wipe the bound registers
    a_short_jump_keep: assert property (dv && i_opc0 == 8'heb |=> !o_bound_init)
        else $error("short jump initialised bound registers");
    a_prefix_keeps_bounds: assert property (dv && i_repeat_not_equal_prefix |=> !o_bound_init)
        else $error("prefixed branch initialised bound registers");
    // Mode transitions
    a_smm_save_offset: assert property (o_smm_save_valid |-> o_smm_save_offset == 16'h7ed0)
        else $error("save map offset wrong");
    a_smi_saves_cfg: assert property (i_system_mgmt_interrupt && i_ce |=> o_smm_save_valid)
        else $error("interrupt entry did not save config");
    a_exit_stores_cfg: assert property (i_vm_exit && i_ce && !i_system_mgmt_interrupt
        && !i_system_mgmt_return |=> o_guest_store_valid)
        else $error("vm exit did not store config");
    a_entry_fail_cause: assert property (o_vm_entry_fail |->
        $past(i_vm_entry && i_entry_restore_config_control))
        else $error("vm entry failed without loading");

    c_bound_init: cover property (dv ##1 o_bound_init);
    c_opcode_fault: cover property (o_invalid_opcode_fault);
    c_entry_fail: cover property (o_vm_entry_fail);
endmodule

bind bounds_ext_mode_branch_control bounds_ext_checker chk_u (.*);
`default_nettype wire

// ==== bench/bounds_ext_mode_branch_control_test.sv ====
// Self-checking bench for the bounds-extension control block
`timescale 1ns/1ps
`default_nettype none
module bounds_ext_mode_branch_control_test;
    logic i_core_clk = 0, i_reset_n = 0, i_ce = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic [7:0] i_paddr = 0, i_opc0 = 0, i_opc1 = 0, ev = 0;
    logic [31:0] i_pwdata = 0, o_prdata, rd;
    logic i_dec_valid = 0, i_is_ext_instr = 0, i_is_mem_form = 0, i_operand_width_prefix_bit = 0;
    logic i_addr_override = 0, i_is_branch = 0, i_repeat_not_equal_prefix = 0, err;
    logic i_exit_wipe_config_control = 0, i_entry_restore_config_control = 0;
    logic [1:0] i_mode = 0, i_bnd_idx = 0;
    logic [2:0] i_modrm_reg = 0;
    logic [63:0] i_bnd_wdata = 0, i_smm_restore_data = 0, i_guest_config = 0;
    wire i_state_save_instr, i_state_restore_instr, i_bnd_wr, i_system_mgmt_interrupt;
    wire i_system_mgmt_return, i_vm_exit, i_vm_entry, i_bound_range_fault;
    logic o_pready, o_pslverr, o_dec_valid, o_opnd_64, o_addr_64, o_invalid_opcode_fault;
    logic o_bound_init, o_smm_save_valid, o_guest_store_valid, o_vm_entry_fail, o_ext_enabled;
    logic [15:0] o_smm_save_offset;
    logic [63:0] o_bnd_rdata, o_smm_save_data, o_guest_store_data;
    int n_mismatch = 0, checks_done = 0;
    logic [7:0] op0 [12] = '{8'he8, 8'hff, 8'hc2, 8'hc3, 8'he9, 8'hff, 8'h70, 8'h7f,
                             8'h0f, 8'h0f, 8'heb, 8'hff};

    // One vector for all single-cycle events, so one task fires any of them
    assign {i_state_save_instr, i_state_restore_instr, i_bnd_wr, i_system_mgmt_interrupt,
            i_system_mgmt_return, i_vm_exit, i_vm_entry, i_bound_range_fault} = ev;

    bounds_ext_mode_branch_control dut_u (.*);

    // 250 MHz core clock
    initial forever #2 i_core_clk = ~i_core_clk;

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until pready is seen high with penable
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_psel <= 1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_core_clk);
        i_penable <= 1;
        // Look at pready once it has settled, never in the edge's own time step
        forever begin
            #1;
            if (o_pready === 1'b1) break;
            @(posedge i_core_clk);
        end
        rd = o_prdata;
        err = o_pslverr;
        @(posedge i_core_clk);
        i_psel <= 0;
        i_penable <= 0;
    endtask

    // Outputs land at the edge that takes the pulse, so look just after it
    task automatic pulse(input logic [7:0] e);
        @(posedge i_core_clk);
        ev <= e;
        @(posedge i_core_clk);
        ev <= 0;
        #1;
    endtask

    task automatic dec(input logic [1:0] m, input logic mem, ov, br, f2,
                       input logic [7:0] o0, o1, input logic [2:0] r);
        @(posedge i_core_clk);
        i_dec_valid <= 1;
        i_mode <= m;
        i_is_mem_form <= mem;
        i_addr_override <= ov;
        i_operand_width_prefix_bit <= ov;
        i_is_branch <= br;
        i_is_ext_instr <= !br;
        i_repeat_not_equal_prefix <= f2;
        i_opc0 <= o0;
        i_opc1 <= o1;
        i_modrm_reg <= r;
        @(posedge i_core_clk);
        i_dec_valid <= 0;
        #1;
    endtask

    // Unmapped access, then status clearing with the extension on and off
    task automatic t_regs;
        apb(0, 8'h20, 0);
        chk(err, 1);
        apb(1, 8'h00, 32'h7);
        apb(1, 8'h0c, 32'h1);
        apb(1, 8'h14, 32'h5);
        pulse(8'h01);
        apb(0, 8'h14, 0);
        chk(rd, 0);
        apb(1, 8'h00, 32'h3);
        apb(1, 8'h14, 32'h5);
        pulse(8'h01);
        chk(o_ext_enabled, 0);
        apb(0, 8'h14, 0);
        chk(rd, 32'h5);
        apb(1, 8'h00, 32'h7);
    endtask

    // Every mode against override present and absent, memory and register forms
    task automatic t_modes;
        for (int m = 0; m < 3; m++)
            for (int k = 0; k < 4; k++) begin
                dec(m[1:0], k[1], k[0], 0, 0, 8'h00, 8'h00, 3'h0);
                chk(o_dec_valid, 1);
                chk(o_addr_64, m == 2);
                chk(o_opnd_64, m == 2);
                chk(o_invalid_opcode_fault, k[1] && (m == 1 ? k[0] : m == 0 && !k[0]));
            end
    endtask

    task automatic t_bounds;
        i_bnd_idx <= 2'h2;
        i_bnd_wdata <= 64'hffff_ffff_1234_5678;
        i_mode <= 2'h1;
        pulse(8'h20);
        pulse(8'h80);
        chk(o_bnd_rdata, 64'h0000_0000_1234_5678);
        pulse(8'h40);
        pulse(8'h80);
        chk(o_bnd_rdata, 64'hffff_ffff_1234_5678);
        dec(2'h2, 0, 0, 1, 0, 8'he8, 8'h00, 3'h0);
        pulse(8'h80);
        chk(o_bnd_rdata, 0);
    endtask

    // Listed near branches, short jump and far call, each preserve and prefix case
    task automatic t_branch;
        for (int p = 0; p < 2; p++) begin
            apb(1, 8'h0c, p ? 32'h3 : 32'h1);
            for (int f = 0; f < 2; f++)
                for (int i = 0; i < 12; i++) begin
                    dec(2'h2, 0, 0, 1, f[0], op0[i], i == 8 ? 8'h80 : 8'h8f,
                        i == 1 ? 3'h2 : i == 5 ? 3'h4 : 3'h3);
                    chk(o_bound_init, i < 10 && !f && !p);
                end
        end
        // One init in the bounds scenario plus ten unprefixed listed branches
        apb(0, 8'h1c, 0);
        chk(rd, 32'hb);
    endtask

    task automatic t_system;
        apb(1, 8'h0c, 32'h1);
        pulse(8'h10);
        chk(o_smm_save_valid, 1);
        chk(o_smm_save_offset, 16'h7ed0);
        chk(o_smm_save_data, 64'h1);
        apb(0, 8'h0c, 0);
        chk(rd, 0);
        i_smm_restore_data <= 64'h0000_8000_0000_0ffd;
        pulse(8'h08);
        apb(0, 8'h0c, 0);
        chk(rd, 32'h1);
        apb(0, 8'h10, 0);
        chk(rd, 32'hffff_8000);
        i_exit_wipe_config_control <= 1;
        pulse(8'h04);
        chk(o_guest_store_valid, 1);
        chk(o_guest_store_data, 64'hffff_8000_0000_0001);
        apb(0, 8'h0c, 0);
        chk(rd, 0);
        i_entry_restore_config_control <= 1;
        i_guest_config <= 64'h1003;
        pulse(8'h02);
        chk(o_vm_entry_fail, 0);
        apb(0, 8'h0c, 0);
        chk(rd, 32'h1003);
        i_guest_config <= 64'h4;
        pulse(8'h02);
        chk(o_vm_entry_fail, 1);
        apb(0, 8'h0c, 0);
        chk(rd, 32'h1003);
    endtask

    task automatic finish_test;
        if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Reset for four cycles, then the scenarios in order
    initial begin
        repeat (4) @(posedge i_core_clk);
        i_reset_n <= 1;
        t_regs;
        t_modes;
        t_bounds;
        t_branch;
        t_system;
        finish_test;
    end

    // Watchdog: far beyond the few hundred cycles the scenarios need
    initial begin
        #20000;
        n_mismatch++;
        finish_test;
    end
endmodule
`default_nettype wire

// ==== logic/bounds_ext_consts.vh ====
// Constants for the bounds-extension mode and branch control block
`ifndef BOUNDS_EXT_CONSTS_VH
`define BOUNDS_EXT_CONSTS_VH

// APB register byte offsets
`define OFF_CTRL 8'h00
`define OFF_UCFG_LO 8'h04
`define OFF_UCFG_HI 8'h08
`define OFF_SCFG_LO 8'h0c
`define OFF_SCFG_HI 8'h10
`define OFF_STAT_LO 8'h14
`define OFF_STAT_HI 8'h18
`define OFF_INIT_CNT 8'h1c

// Control register fields
`define CTRL_OS_SAVE_BIT 0
`define CTRL_REGS_STATE_BIT 1
`define CTRL_CSR_STATE_BIT 2
`define CTRL_CPL_LO 3
`define CTRL_CPL_HI 4

// Configuration register fields
`define CFG_ENABLE_BIT 0
`define CFG_PRESERVE_BIT 1
`define CFG_RSVD_HI 11
`define CFG_RSVD_LO 2
`define CFG_RSVD_MASK 64'h0000_0000_0000_0ffc

// Highest implemented linear address bit
`define LIN_ADDR_TOP 47

// Operating modes
`define MODE_16 2'h0
`define MODE_32 2'h1
`define MODE_64 2'h2

// Privilege level of user code
`define CPL_USER 2'h3

// Opcode bytes
`define OPC_CALL_REL 8'he8
`define OPC_JMP_REL 8'he9
`define OPC_GRP5 8'hff
`define OPC_RET_IMM 8'hc2
`define OPC_RET 8'hc3
`define OPC_ESC 8'h0f
`define OPC_JCC_SHORT_HI 4'h7
`define OPC_JCC_NEAR_HI 4'h8
`define MODRM_CALL_IND 3'h2
`define MODRM_JMP_IND 3'h4

// System management save map offset of supervisor configuration
`define SMM_CFG_OFFSET 16'h7ed0

// Reset values
`define CFG_RESET 64'h0000_0000_0000_0000
`define BND_INIT_VALUE 64'h0000_0000_0000_0000

`endif

// ==== logic/bounds_ext_mode_branch_control.v ====
// Bounds-extension mode, branch-init, status and supervisor config control
// Function
// - 64-bit mode forces 64-bit bound operands and addressing, ignoring width prefixes.
// - State save and restore move full 64-bit bound values in every mode.
// - Compatibility and legacy modes use 32-bit bound operands and addressing.
// - Outside 64-bit mode a bound register write clears its upper 32 bits.
// - Register-only forms ignore the address-size override prefix.
// - Enabled: 64-bit mode always 64-bit addressing; 32-bit mode override faults.
// - Enabled 16-bit mode: override gives 32-bit addressing, absence faults.
// - F2 on near call, return, jump and conditional jumps is the bounds prefix.
// - Far branches and short jump EB never initialise bound registers.
// - Preserve bit zero: unprefixed listed branch initialises all four bound registers.
// - Preserve bit one: unprefixed listed branch leaves bound registers unchanged.
// - Prefixed listed branch always leaves bound registers unchanged.
// - Near call is E8 and FF/2; near jump is E9 and FF/4.
// - Near return is C2, C3; conditional jumps 70-7F and 0F 80-8F.
// - Legacy bound-check fault with extension enabled zeroes the status register.
// - Enabled needs save-enable, both state bits and enable of CURRENT_PRIVILEGE_LEVEL-selected config.
// - Otherwise the legacy bound-check leaves the status register alone.
// - System-management entry saves supervisor config at 7ED0H, then clears it.
// - Return restores supervisor config, zeroing bits 11:2 and sign-extending address.
// - VM exit stores supervisor config to guest field; clears it if wipe set.
// - VM entry loads supervisor config from guest field when restore control set.
// - VM entry fails late when the guest value would fault a privileged write.
`timescale 1ns/1ps
`default_nettype none
`include "bounds_ext_consts.vh"

module bounds_ext_mode_branch_control (
    input wire i_core_clk,
    input wire i_reset_n,
    input wire i_ce,
    // APB slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    // Instruction decode request
    input wire i_dec_valid,
    input wire [1:0] i_mode,
    input wire i_is_ext_instr,
    input wire i_is_mem_form,
    input wire i_operand_width_prefix_bit,
    input wire i_addr_override,
    input wire i_is_branch,
    input wire i_repeat_not_equal_prefix,
    input wire [7:0] i_opc0,
    input wire [7:0] i_opc1,
    input wire [2:0] i_modrm_reg,
    output reg o_dec_valid,
    output reg o_opnd_64,
    output reg o_addr_64,
    output reg o_invalid_opcode_fault,
    output reg o_bound_init,
    // Bound register writes and state save/restore
    input wire i_bnd_wr,
    input wire [1:0] i_bnd_idx,
    input wire [63:0] i_bnd_wdata,
    input wire i_state_restore_instr,
    input wire i_state_save_instr,
    output reg [63:0] o_bnd_rdata,
    // Legacy bound-check fault
    input wire i_bound_range_fault,
    // System management
    input wire i_system_mgmt_interrupt,
    input wire i_system_mgmt_return,
    input wire [63:0] i_smm_restore_data,
    output reg o_smm_save_valid,
    output reg [15:0] o_smm_save_offset,
    output reg [63:0] o_smm_save_data,
    // Virtual machine transitions
    input wire i_vm_exit,
    input wire i_exit_wipe_config_control,
    input wire i_vm_entry,
    input wire i_entry_restore_config_control,
    input wire [63:0] i_guest_config,
    output reg o_guest_store_valid,
    output reg [63:0] o_guest_store_data,
    output reg o_vm_entry_fail,
    output reg o_ext_enabled
);

    reg [4:0] ctrl_q;
    reg [63:0] user_bounds_config_q;
    reg [63:0] supervisor_bounds_config_q;
    reg [63:0] bounds_fault_status_q;
    reg [31:0] init_count_q;
    reg [63:0] bound_regs_zero_to_three_q [0:3];

    wire [1:0] current_privilege_level;
    wire [63:0] active_bounds_config;
    wire ext_enabled;
    wire preserve_bounds_on_branch;
    wire near_call;
    wire near_jmp;
    wire near_ret;
    wire cond_jmp;
    wire listed_branch;
    wire do_init;
    wire addr_fault;
    wire [63:0] rsm_value;
    wire guest_bad;
    wire apb_setup;
    wire apb_access;
    wire apb_wr;
    wire [63:0] bnd_wr_value;

    // Privilege level selects user or supervisor configuration
    assign current_privilege_level = ctrl_q[`CTRL_CPL_HI:`CTRL_CPL_LO];
    assign active_bounds_config = (current_privilege_level == `CPL_USER) ? user_bounds_config_q
                                                      : supervisor_bounds_config_q;
    assign ext_enabled = ctrl_q[`CTRL_OS_SAVE_BIT] & ctrl_q[`CTRL_REGS_STATE_BIT] &
                         ctrl_q[`CTRL_CSR_STATE_BIT] &
                         active_bounds_config[`CFG_ENABLE_BIT];
    assign preserve_bounds_on_branch = active_bounds_config[`CFG_PRESERVE_BIT];

    // Near branch opcode classes; far forms and EB fall outside every class
    assign near_call = (i_opc0 == `OPC_CALL_REL) |
                       ((i_opc0 == `OPC_GRP5) & (i_modrm_reg == `MODRM_CALL_IND));
    assign near_jmp = (i_opc0 == `OPC_JMP_REL) |
                      ((i_opc0 == `OPC_GRP5) & (i_modrm_reg == `MODRM_JMP_IND));
    assign near_ret = (i_opc0 == `OPC_RET_IMM) | (i_opc0 == `OPC_RET);
    assign cond_jmp = (i_opc0[7:4] == `OPC_JCC_SHORT_HI) |
                      ((i_opc0 == `OPC_ESC) & (i_opc1[7:4] == `OPC_JCC_NEAR_HI));
    assign listed_branch = i_is_branch & (near_call | near_jmp | near_ret | cond_jmp);

    // F2 acts as the bounds prefix; a disabled extension never initialises
    assign do_init = i_dec_valid & listed_branch & ext_enabled &
                     ~i_repeat_not_equal_prefix &
                     ~preserve_bounds_on_branch;

    // Address-size override only matters for memory forms outside 64-bit mode
    assign addr_fault = i_is_ext_instr & i_is_mem_form & ext_enabled &
                        (((i_mode == `MODE_32) & i_addr_override) |
                         ((i_mode == `MODE_16) & ~i_addr_override));

    // Restore forces reserved bits low and keeps the address canonical
    assign rsm_value = {{(63 - `LIN_ADDR_TOP){i_smm_restore_data[`LIN_ADDR_TOP]}},
                        i_smm_restore_data[`LIN_ADDR_TOP:12],
                        10'h000,
                        i_smm_restore_data[1:0]};

    // Guest value that a privileged write would refuse
    assign guest_bad = ((i_guest_config & `CFG_RSVD_MASK) != 64'h0) |
                       (i_guest_config[63:`LIN_ADDR_TOP] !=
                        {(64 - `LIN_ADDR_TOP){i_guest_config[`LIN_ADDR_TOP]}});

    // Upper half dropped for writes outside 64-bit mode
    assign bnd_wr_value = (i_mode == `MODE_64) ? i_bnd_wdata
                                               : {32'h0000_0000, i_bnd_wdata[31:0]};

    // APB phases: one wait-free access cycle after setup
    assign apb_setup = i_psel & ~i_penable;
    assign apb_access = i_psel & i_penable & o_pready;
    assign apb_wr = apb_access & i_pwrite;

    // Decode results, one cycle after the request
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_dec_valid <= 1'b0;
            o_opnd_64 <= 1'b0;
            o_addr_64 <= 1'b0;
            o_invalid_opcode_fault <= 1'b0;
            o_bound_init <= 1'b0;
            o_ext_enabled <= 1'b0;
        end else if (i_ce) begin
            o_dec_valid <= i_dec_valid;
            o_opnd_64 <= i_dec_valid & (i_mode == `MODE_64);
            o_addr_64 <= i_dec_valid & (i_mode == `MODE_64);
            o_invalid_opcode_fault <= i_dec_valid & addr_fault;
            o_bound_init <= do_init;
            o_ext_enabled <= ext_enabled;
        end
    end

    // Four bound registers: init wins over an instruction write in the same cycle
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_bnd
            always @(posedge i_core_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    bound_regs_zero_to_three_q[g] <= `BND_INIT_VALUE;
                end else if (i_ce) begin
                    if (do_init) begin
                        bound_regs_zero_to_three_q[g] <= `BND_INIT_VALUE;
                    end else if (i_state_restore_instr && i_bnd_idx == g) begin
                        bound_regs_zero_to_three_q[g] <= i_bnd_wdata;
                    end else if (i_bnd_wr && i_bnd_idx == g) begin
                        bound_regs_zero_to_three_q[g] <= bnd_wr_value;
                    end
                end
            end
        end
    endgenerate

    // Save path always reads the full 64 bits
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_bnd_rdata <= 64'h0;
        end else if (i_ce && i_state_save_instr) begin
            o_bnd_rdata <= bound_regs_zero_to_three_q[i_bnd_idx];
        end
    end

    // Control and user configuration, software only
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q <= 5'h00;
            user_bounds_config_q <= `CFG_RESET;
        end else if (i_ce && apb_wr) begin
            case (i_paddr)
                `OFF_CTRL: ctrl_q <= i_pwdata[4:0];
                `OFF_UCFG_LO: user_bounds_config_q[31:0] <= i_pwdata & 32'hffff_f003;
                `OFF_UCFG_HI: user_bounds_config_q[63:32] <= i_pwdata;
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // Supervisor configuration: mode transitions take priority over software
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            supervisor_bounds_config_q <= `CFG_RESET;
        end else if (i_ce) begin
            if (i_system_mgmt_interrupt) begin
                supervisor_bounds_config_q <= `CFG_RESET;
            end else if (i_system_mgmt_return) begin
                supervisor_bounds_config_q <= rsm_value;
            end else if (i_vm_exit) begin
                if (i_exit_wipe_config_control) begin
                    supervisor_bounds_config_q <= `CFG_RESET;
                end
            end else if (i_vm_entry) begin
                if (i_entry_restore_config_control && !guest_bad) begin
                    supervisor_bounds_config_q <= i_guest_config;
                end
            end else if (apb_wr && i_paddr == `OFF_SCFG_LO) begin
                supervisor_bounds_config_q[31:0] <= i_pwdata & 32'hffff_f003;
            end else if (apb_wr && i_paddr == `OFF_SCFG_HI) begin
                supervisor_bounds_config_q[63:32] <= i_pwdata;
            end
        end
    end

    // Save outputs; old value captured in the clearing cycle
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_smm_save_valid <= 1'b0;
            o_smm_save_offset <= 16'h0000;
            o_smm_save_data <= 64'h0;
            o_guest_store_valid <= 1'b0;
            o_guest_store_data <= 64'h0;
            o_vm_entry_fail <= 1'b0;
        end else if (i_ce) begin
            o_smm_save_valid <= i_system_mgmt_interrupt;
            o_smm_save_offset <= `SMM_CFG_OFFSET;
            o_guest_store_valid <= i_vm_exit & ~i_system_mgmt_interrupt &
                                   ~i_system_mgmt_return;
            o_vm_entry_fail <= i_vm_entry & i_entry_restore_config_control & guest_bad &
                               ~i_system_mgmt_interrupt & ~i_system_mgmt_return &
                               ~i_vm_exit;
            if (i_system_mgmt_interrupt) begin
                o_smm_save_data <= supervisor_bounds_config_q;
            end
            if (i_vm_exit) begin
                o_guest_store_data <= supervisor_bounds_config_q;
            end
        end
    end

    // Status: hardware zeroing beats a software write in the same cycle
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bounds_fault_status_q <= 64'h0;
        end else if (i_ce) begin
            if (i_bound_range_fault && ext_enabled) begin
                bounds_fault_status_q <= 64'h0;
            end else if (apb_wr && i_paddr == `OFF_STAT_LO) begin
                bounds_fault_status_q[31:0] <= i_pwdata;
            end else if (apb_wr && i_paddr == `OFF_STAT_HI) begin
                bounds_fault_status_q[63:32] <= i_pwdata;
            end
        end
    end

    // Count of initialising branches, visible to software
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            init_count_q <= 32'h0;
        end else if (i_ce && do_init) begin
            init_count_q <= init_count_q + 32'h1;
        end
    end

    // APB answer: data sampled at setup, ready in the access cycle
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0;
        end else if (i_ce) begin
            o_pready <= apb_setup;
            if (apb_setup) begin
                o_pslverr <= 1'b0;
                case (i_paddr)
                    `OFF_CTRL: o_prdata <= {27'h0, ctrl_q};
                    `OFF_UCFG_LO: o_prdata <= user_bounds_config_q[31:0];
                    `OFF_UCFG_HI: o_prdata <= user_bounds_config_q[63:32];
                    `OFF_SCFG_LO: o_prdata <= supervisor_bounds_config_q[31:0];
                    `OFF_SCFG_HI: o_prdata <= supervisor_bounds_config_q[63:32];
                    `OFF_STAT_LO: o_prdata <= bounds_fault_status_q[31:0];
                    `OFF_STAT_HI: o_prdata <= bounds_fault_status_q[63:32];
                    `OFF_INIT_CNT: o_prdata <= init_count_q;
                    default: begin
                        o_prdata <= 32'h0;
                        o_pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire
